// ===== shp_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`default_nettype none
module shp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
    } shp_fifo_state_t;

    shp_fifo_state_t st_reg;
    shp_fifo_state_t st_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    // Honest flags straight from the occupancy count
    assign in_ready = (st_reg.count != (AW+1)'(DEPTH));
    assign out_valid = (st_reg.count != '0);
    assign out_data = mem[st_reg.rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer and count update
    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
        end
        if (pop) begin
            st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            st_next.count = st_reg.count + 1'b1;
        end else if (pop && !push) begin
            st_next.count = st_reg.count - 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Storage needs no reset; only written entries are ever read
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[st_reg.wr_ptr] <= in_data;
        end
    end
endmodule
`default_nettype wire

// ===== shp_host_model.sv
// Behavioural host: serial frames both ways and send permission
`default_nettype none
module shp_host_model (
    // Clock
    input wire logic sys_clk,
    // Serial pins
    input wire logic serial_tx,
    input wire logic host_ready_n,
    output var logic serial_rx,
    output var logic host_permit_n
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BITN = int'(shp_pkg::BIT_CYCLES);
    // Idle line high, permission withheld until granted
    initial begin
        serial_rx = 1'h1;
        host_permit_n = 1'h1;
    end
    // Low allows the device to send, high withholds
    task automatic permit(input logic allow);
        host_permit_n = !allow;
    endtask
    // One 8N1 frame, LSB first; only checked per character
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'h1, b, 1'h0};
        while (host_ready_n !== 1'h0) @(negedge sys_clk);
        for (int i = 0; i < 10; i++) begin
            serial_rx = f[i];
            repeat (BITN) @(negedge sys_clk);
        end
    endtask
    // Mid-bit sampling of one frame, bounded wait for the start
    task automatic recv_byte(output logic [7:0] b, output logic stop);
        int n;
        n = 0;
        while (serial_tx !== 1'h0 && n < 4000) begin
            @(negedge sys_clk);
            n++;
        end
        repeat (BITN / 2) @(negedge sys_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BITN) @(negedge sys_clk);
            b[i] = serial_tx;
        end
        repeat (BITN) @(negedge sys_clk);
        stop = serial_tx;
    endtask
endmodule
`default_nettype wire

// ===== shp_host_pins.sv
// Host-facing pin logic: serial flow control, SPI direction, I/O, wake
`default_nettype none
module shp_host_pins (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Serial data port to host
    input wire logic serial_rx,
    output logic serial_tx,
    output logic host_ready_n,
    input wire logic host_permit_n,
    // Received bytes towards the core
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [7:0] rx_data,
    // Bytes from the core for the host
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data,
    // SPI role and core-side SPI signals
    input wire logic spi_master,
    input wire logic spi_miso_drive,
    input wire logic spi_mosi_drive,
    input wire logic spi_sclk_drive,
    input wire logic spi_ss_n_drive,
    input wire logic spi_slave_data_ok,
    // SPI pins, each as in/out/enable
    input wire logic spi_miso_i,
    output logic spi_miso_o,
    output logic spi_miso_oe,
    input wire logic spi_mosi_i,
    output logic spi_mosi_o,
    output logic spi_mosi_oe,
    input wire logic spi_sclk_i,
    output logic spi_sclk_o,
    output logic spi_sclk_oe,
    input wire logic spi_ss_n_i,
    output logic spi_ss_n_o,
    output logic spi_ss_n_oe,
    // Configurable I/O pins
    input wire logic [3:0] gpio_dir_out,
    input wire logic [3:0] gpio_drive,
    input wire logic [3:0] gpio_i,
    output logic [3:0] gpio_o,
    output logic [3:0] gpio_oe,
    output logic [3:0] gpio_pullup_en,
    // Duty-cycle output
    input wire logic [15:0] duty_setting,
    output logic duty_cycle_output,
    // Converter readings
    input wire logic [9:0] analog_sample_input_a,
    input wire logic [9:0] analog_sample_input_b,
    output logic [9:0] reading_a,
    output logic [9:0] reading_b,
    // Wake control
    input wire logic wake_request_in,
    input wire logic radio_busy,
    input wire logic uncommissioned,
    input wire logic [15:0] wake_timeout,
    output logic awake_out
);
    // Block state outside the FIFO lives in one register, filled by one process
    shp_pkg::shp_state_t st_reg;
    shp_pkg::shp_state_t st_next;
    // Room in the host data buffer
    logic fifo_in_ready;
    // Slave role with the select pin held low by the far master
    logic spi_slave_active;

    // Buffer for bytes from the host, drained by the core; sixteen
    // entries let the core fall behind while the host keeps sending
    shp_fifo #(
        .WIDTH(shp_pkg::DATA_BITS),
        .DEPTH(shp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .in_valid(st_reg.rx_push),
        .in_ready(fifo_in_ready),
        .in_data(st_reg.rx_data),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_data)
    );

    // Ready only with buffer room and, in slave role, core acceptance
    // Combinational, so the host sees a full buffer in the same cycle
    assign spi_slave_active = !spi_master && !spi_ss_n_i;
    assign host_ready_n = !(fifo_in_ready &&
        (!spi_slave_active || spi_slave_data_ok));

    // Permission checked only between characters
    // A withdrawal mid-frame never cuts a character short
    assign tx_ready = !st_reg.tx_busy && !host_permit_n;
    assign serial_tx = st_reg.tx_line;

    // SPI pin directions follow the role
    // A role change turns the pins around at once; idle the bus first
    assign spi_miso_oe = !spi_master;
    assign spi_miso_o = spi_miso_drive;
    assign spi_mosi_oe = spi_master;
    assign spi_mosi_o = spi_mosi_drive;
    assign spi_sclk_oe = spi_master;
    assign spi_sclk_o = spi_sclk_drive;
    assign spi_ss_n_oe = spi_master;
    assign spi_ss_n_o = spi_ss_n_drive;

    // Pull-up only on pins set as inputs
    // Drive and pull-up are exclusive, so a pin never fights itself
    for (genvar i = 0; i < shp_pkg::GPIO_COUNT; i++) begin : g_gpio
        assign gpio_oe[i] = gpio_dir_out[i];
        assign gpio_o[i] = gpio_drive[i];
        assign gpio_pullup_en[i] = !gpio_dir_out[i];
    end

    // Registered outputs straight from the state
    assign duty_cycle_output = st_reg.pwm_out;
    assign reading_a = st_reg.adc_a;
    assign reading_b = st_reg.adc_b;
    assign awake_out = (st_reg.wake == shp_pkg::SHP_AWAKE);

    // Next-state logic for all engines
    always_comb begin
        st_next = st_reg;
        // Push is a one-cycle strobe
        st_next.rx_push = 1'b0;

        // Receiver: find start edge, sample mid-bit
        // The start is checked again at mid-bit to reject short glitches
        if (!st_reg.rx_busy) begin
            if (!serial_rx) begin
                st_next.rx_busy = 1'b1;
                st_next.rx_cnt = shp_pkg::HALF_BIT_CYCLES;
                st_next.rx_bit = 4'h0;
            end
        end else if (st_reg.rx_cnt != shp_pkg::CNT_RESET) begin
            st_next.rx_cnt = st_reg.rx_cnt - 1'b1;
        end else begin
            st_next.rx_cnt = shp_pkg::BIT_CYCLES - 1'b1;
            st_next.rx_bit = st_reg.rx_bit + 1'b1;
            if (st_reg.rx_bit == 4'h0 && serial_rx) begin
                st_next.rx_busy = 1'b0;  // Glitch, not a start bit
            end else if (st_reg.rx_bit != 4'h0) begin
                st_next.rx_shift = {serial_rx, st_reg.rx_shift[7:1]};
            end
            if (st_reg.rx_bit == shp_pkg::RX_LAST_BIT) begin
                // Hand over at the last data bit; stop is not checked
                st_next.rx_data = {serial_rx, st_reg.rx_shift[7:1]};
                // A host ignoring flow control loses the byte here
                st_next.rx_push = 1'b1;
            end
            // Stay busy up to mid stop bit: a low last data bit
            // would otherwise look like the next start edge
            if (st_reg.rx_bit == shp_pkg::RX_LAST_BIT + 4'h1) begin
                st_next.rx_busy = 1'b0;
            end
        end

        // Transmitter: a started frame always runs to its stop bit
        // Permission gates only the start of a new frame
        if (!st_reg.tx_busy) begin
            st_next.tx_line = 1'b1;
            if (tx_valid && !host_permit_n) begin
                st_next.tx_busy = 1'b1;
                st_next.tx_shift = {1'b1, tx_data, 1'b0};
                st_next.tx_bit = 4'h0;
                st_next.tx_cnt = shp_pkg::CNT_RESET;
            end
        end else if (st_reg.tx_cnt != shp_pkg::CNT_RESET) begin
            st_next.tx_cnt = st_reg.tx_cnt - 1'b1;
        end else if (st_reg.tx_bit == shp_pkg::TX_FRAME_BITS) begin
            // Stop bit has had its full time; go idle
            st_next.tx_busy = 1'b0;
        end else begin
            st_next.tx_line = st_reg.tx_shift[0];
            st_next.tx_shift = {1'b1, st_reg.tx_shift[9:1]};
            st_next.tx_bit = st_reg.tx_bit + 1'b1;
            st_next.tx_cnt = shp_pkg::BIT_CYCLES - 1'b1;
        end

        // Free-running 16-bit duty counter
        // Registered compare: the output lags the counter by one cycle
        st_next.pwm_cnt = st_reg.pwm_cnt + 1'b1;
        st_next.pwm_out = (st_reg.pwm_cnt < duty_setting);

        // Converter readings captured every cycle at 10 bits
        // The converter itself sits outside; this stage holds its word
        st_next.adc_a = analog_sample_input_a;
        st_next.adc_b = analog_sample_input_b;

        // Wake control: activity keeps the timeout clear
        // Timer counts idle cycles only; any hold cause restarts the wait
        // Asleep, only the wake request counts; hold causes are ignored
        unique case (st_reg.wake)
            shp_pkg::SHP_AWAKE: begin
                if (wake_request_in || st_reg.rx_busy || radio_busy ||
                    uncommissioned) begin
                    st_next.wake_timer = '0;
                end else if (st_reg.wake_timer >= wake_timeout) begin
                    st_next.wake = shp_pkg::SHP_ASLEEP;
                    st_next.wake_timer = '0;
                end else begin
                    st_next.wake_timer = st_reg.wake_timer + 1'b1;
                end
            end
            shp_pkg::SHP_ASLEEP: begin
                if (wake_request_in) begin
                    st_next.wake = shp_pkg::SHP_AWAKE;
                end
            end
        endcase
    end

    // Single state register; low reset holds everything idle
    // Line idle high and awake after reset, as the host expects
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
            st_reg.tx_line <= 1'b1;
            st_reg.wake <= shp_pkg::SHP_AWAKE;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule
`default_nettype wire

// ===== shp_host_pins_checker.sv
// Checker of pin direction, flow control and reset rules
`default_nettype none
module shp_host_pins_checker (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Watched pins
    input wire logic spi_master,
    input wire logic spi_ss_n_i,
    input wire logic spi_slave_data_ok,
    input wire logic host_ready_n,
    input wire logic host_permit_n,
    input wire logic tx_ready,
    input wire logic spi_miso_oe,
    input wire logic spi_mosi_oe,
    input wire logic spi_sclk_oe,
    input wire logic spi_ss_n_oe,
    input wire logic [3:0] gpio_dir_out,
    input wire logic [3:0] gpio_pullup_en,
    input wire logic serial_tx,
    input wire logic awake_out,
    input wire logic wake_request_in
);
    // One domain, so one clocking and one disable
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);
    AST_READY: assert property (
        !spi_master && !spi_ss_n_i && !spi_slave_data_ok |-> host_ready_n)
        else $error("ready shown while slave data refused");
    AST_PERMIT: assert property (
        tx_ready |-> !host_permit_n)
        else $error("send offered without permission");
    AST_PULLUP: assert property (
        gpio_pullup_en == ~gpio_dir_out)
        else $error("pull-up not tied to input direction");
    AST_MISO: assert property (
        spi_miso_oe != spi_master)
        else $error("miso direction wrong for role");
    AST_MOSI_SCLK: assert property (
        spi_mosi_oe == spi_master && spi_sclk_oe == spi_master)
        else $error("mosi or sclk direction wrong for role");
    AST_SELECT: assert property (
        spi_ss_n_oe == spi_master)
        else $error("slave select direction wrong for role");
    AST_RESET: assert property (
        $rose(arst_n) |-> serial_tx && awake_out)
        else $error("outputs not at reset values");
    AST_WAKE: assert property (
        !awake_out && wake_request_in |=> awake_out)
        else $error("wake request ignored");
endmodule
bind shp_host_pins shp_host_pins_checker shp_host_pins_checker_i (
    .sys_clk, .arst_n, .spi_master, .spi_ss_n_i, .spi_slave_data_ok,
    .host_ready_n, .host_permit_n, .tx_ready, .spi_miso_oe, .spi_mosi_oe,
    .spi_sclk_oe, .spi_ss_n_oe, .gpio_dir_out, .gpio_pullup_en,
    .serial_tx, .awake_out, .wake_request_in
);
`default_nettype wire

// ===== shp_host_pins_tb.sv
// Self-checking bench for the host pin block
`default_nettype none
module shp_host_pins_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, arst_n, serial_rx, host_permit_n, rx_ready, tx_valid;
    logic spi_master, spi_ss_n_i, spi_slave_data_ok, wake_request_in;
    logic radio_busy, uncommissioned, serial_tx, host_ready_n, rx_valid;
    logic tx_ready, spi_miso_oe, spi_mosi_oe, spi_sclk_oe, spi_ss_n_oe;
    logic awake_out, duty_cycle_output, stop_bit;
    logic [3:0] gpio_dir_out, gpio_oe, gpio_pullup_en, gpio_o, spi_o;
    logic [7:0] rx_data, tx_data, got;
    logic [9:0] analog_sample_input_a, analog_sample_input_b;
    logic [9:0] reading_a, reading_b;
    logic [15:0] duty_setting, wake_timeout;
    int n_mismatch = 0;
    int n_tests = 0;
    // Role, direction, select, slave ok -> miso oe, pull-ups, ready
    typedef struct packed {
        logic m; logic [3:0] dir; logic ss; logic ok;
        logic miso_oe; logic [3:0] pu; logic rdy_n;
    } shp_row_t;
    localparam shp_row_t ROWS [4] = '{
        '{1'h1, 4'hF, 1'h1, 1'h0, 1'h0, 4'h0, 1'h0},
        '{1'h0, 4'h0, 1'h1, 1'h0, 1'h1, 4'hF, 1'h0},
        '{1'h0, 4'h5, 1'h0, 1'h0, 1'h1, 4'hA, 1'h1},
        '{1'h0, 4'hA, 1'h0, 1'h1, 1'h1, 4'h5, 1'h0}
    };
    // Pin values borrow the direction bits so no input sits constant
    shp_host_pins shp_host_pins_i (
        .sys_clk, .arst_n, .serial_rx, .serial_tx, .host_ready_n,
        .host_permit_n, .rx_valid, .rx_ready, .rx_data, .tx_valid,
        .tx_ready, .tx_data, .spi_master, .spi_slave_data_ok,
        .spi_miso_drive(gpio_dir_out[0]), .spi_mosi_drive(gpio_dir_out[1]),
        .spi_sclk_drive(gpio_dir_out[2]), .spi_ss_n_drive(gpio_dir_out[3]),
        .spi_miso_i(gpio_dir_out[1]), .spi_miso_o(spi_o[0]), .spi_miso_oe,
        .spi_mosi_i(gpio_dir_out[2]), .spi_mosi_o(spi_o[1]), .spi_mosi_oe,
        .spi_sclk_i(gpio_dir_out[3]), .spi_sclk_o(spi_o[2]), .spi_sclk_oe,
        .spi_ss_n_i, .spi_ss_n_o(spi_o[3]), .spi_ss_n_oe, .gpio_dir_out,
        .gpio_drive(gpio_dir_out), .gpio_i(~gpio_dir_out), .gpio_o,
        .gpio_oe, .gpio_pullup_en, .duty_setting, .duty_cycle_output,
        .analog_sample_input_a, .analog_sample_input_b, .reading_a,
        .reading_b, .wake_request_in, .radio_busy, .uncommissioned,
        .wake_timeout, .awake_out
    );
    shp_host_model shp_host_model_i (
        .sys_clk, .serial_tx, .host_ready_n, .serial_rx, .host_permit_n
    );
    // Four-state compare, counted
    task automatic chk(input logic [15:0] g, input logic [15:0] e,
        input string what);
        n_tests++;
        if (g !== e) begin
            $display("[ERR] %0t %s", $time, what);
            n_mismatch++;
        end
    endtask
    task automatic tally_and_finish();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // 40 ns clock
    initial begin
        sys_clk = 1'h0;
        forever #20 sys_clk = ~sys_clk;
    end
    // Two serial frames overlap, so about 30k cycles are needed
    initial begin
        repeat (60000) @(posedge sys_clk);
        n_mismatch++;
        tally_and_finish();
    end
    // Main sequence; a FIFO fill takes 16 frames, too long for this run
    initial begin
        {arst_n, rx_ready, tx_valid, wake_request_in} = 4'h0;
        {radio_busy, uncommissioned, spi_slave_data_ok} = 3'h0;
        {spi_master, spi_ss_n_i, tx_data, gpio_dir_out} = 14'h0;
        {analog_sample_input_a, analog_sample_input_b} = 20'h0;
        duty_setting = 16'h0000;
        wake_timeout = 16'hFFFF;
        repeat (8) @(negedge sys_clk);
        chk({serial_tx, awake_out, rx_valid}, 3'h6, "reset");
        arst_n = 1'h1;
        $display("reset done");
        foreach (ROWS[i]) begin
            {spi_master, gpio_dir_out} = {ROWS[i].m, ROWS[i].dir};
            {spi_ss_n_i, spi_slave_data_ok} = {ROWS[i].ss, ROWS[i].ok};
            @(negedge sys_clk);
            chk(spi_miso_oe, ROWS[i].miso_oe, "miso");
            chk({spi_mosi_oe, spi_sclk_oe}, {2{ROWS[i].m}}, "mosi");
            chk(spi_ss_n_oe, ROWS[i].m, "select");
            chk(gpio_pullup_en, ROWS[i].pu, "pull-up");
            chk(gpio_oe, ROWS[i].dir, "io dir");
            chk(host_ready_n, ROWS[i].rdy_n, "ready");
            // Core drive values borrow the direction bits
            chk(spi_o, ROWS[i].dir, "spi drive");
            chk(gpio_o, ROWS[i].dir, "io drive");
        end
        $display("pin table done");
        chk(duty_cycle_output, 1'h0, "duty low");
        analog_sample_input_a = 10'h2A5;
        analog_sample_input_b = 10'h15A;
        duty_setting = 16'hFFFF;
        repeat (2) @(negedge sys_clk);
        chk(reading_a, 10'h2A5, "adc a");
        chk(reading_b, 10'h15A, "adc b");
        chk(duty_cycle_output, 1'h1, "duty");
        wake_timeout = 16'h0010;
        repeat (40) @(negedge sys_clk);
        chk(awake_out, 1'h0, "sleep");
        wake_request_in = 1'h1;
        @(negedge sys_clk);
        chk(awake_out, 1'h1, "wake");
        {wake_request_in, radio_busy} = 2'h1;
        repeat (40) @(negedge sys_clk);
        chk(awake_out, 1'h1, "held by radio");
        {radio_busy, uncommissioned} = 2'h1;
        repeat (40) @(negedge sys_clk);
        chk(awake_out, 1'h1, "held uncommissioned");
        $display("converter and wake done");
        {wake_timeout, spi_master, tx_data, tx_valid} = 26'h3FFFF87;
        repeat (100) @(negedge sys_clk);
        chk({tx_ready, serial_tx}, 2'h1, "withheld");
        fork
            shp_host_model_i.recv_byte(got, stop_bit);
            shp_host_model_i.send_byte(8'h96);
            begin
                shp_host_model_i.permit(1'h1);
                @(negedge sys_clk);
                tx_valid = 1'h0;
                repeat (5 * shp_pkg::BIT_CYCLES) @(negedge sys_clk);
                shp_host_model_i.permit(1'h0);
            end
        join
        chk({got, stop_bit}, 9'h187, "sent frame");
        // A byte waits while permission stays withdrawn
        tx_valid = 1'h1;
        repeat (8) @(negedge sys_clk);
        chk({tx_ready, serial_tx}, 2'h1, "withdrawn");
        tx_valid = 1'h0;
        shp_host_model_i.permit(1'h1);
        @(negedge sys_clk);
        chk(tx_ready, 1'h1, "resumed");
        shp_host_model_i.permit(1'h0);
        for (int i = 0; i < 3000 && rx_valid !== 1'h1; i++) begin
            @(negedge sys_clk);
        end
        chk(rx_valid, 1'h1, "rx valid");
        chk(rx_data, 8'h96, "received");
        rx_ready = 1'h1;
        @(negedge sys_clk);
        rx_ready = 1'h0;
        chk(rx_valid, 1'h0, "popped");
        $display("serial done");
        // Reset in mid-run returns registered outputs to their reset values, then lets go
        arst_n = 1'h0;
        @(negedge sys_clk);
        chk({serial_tx, awake_out, duty_cycle_output}, 3'h6, "rst2");
        chk(reading_a, 10'h000, "rst2 reading");
        arst_n = 1'h1;
        repeat (2) @(negedge sys_clk);
        chk(reading_a, 10'h2A5, "after reset");
        $display("second reset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ===== shp_pkg.sv
// Package of constants and types for the host pin block
`default_nettype none
package shp_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int BAUD_RATE = 9_600;
    // Cycles per serial bit, and half of it for mid-bit sampling
    localparam logic [11:0] BIT_CYCLES = 12'(CLK_HZ / BAUD_RATE);
    localparam logic [11:0] HALF_BIT_CYCLES = 12'(CLK_HZ / BAUD_RATE / 2);
    localparam int DATA_BITS = 8;
    localparam logic [3:0] RX_LAST_BIT = 4'h8;  // Start plus eight data
    localparam logic [3:0] TX_FRAME_BITS = 4'hA; // Start, eight, stop
    localparam int FIFO_DEPTH = 16;
    localparam int PWM_BITS = 16;
    localparam int ADC_BITS = 10;
    localparam int GPIO_COUNT = 4;
    localparam int WAKE_TIMER_BITS = 16;
    localparam logic [11:0] CNT_RESET = 12'h000;
    localparam logic [15:0] PWM_RESET = 16'h0000;
    localparam logic [9:0] ADC_RESET = 10'h000;

    typedef enum logic {SHP_AWAKE, SHP_ASLEEP} shp_wake_t;

    typedef struct packed {
        logic rx_busy;
        logic [11:0] rx_cnt;
        logic [3:0] rx_bit;
        logic [7:0] rx_shift;
        logic rx_push;
        logic [7:0] rx_data;
        logic tx_busy;
        logic [11:0] tx_cnt;
        logic [3:0] tx_bit;
        logic [9:0] tx_shift;
        logic tx_line;
        logic [15:0] pwm_cnt;
        logic pwm_out;
        shp_wake_t wake;
        logic [15:0] wake_timer;
        logic [9:0] adc_a;
        logic [9:0] adc_b;
    } shp_state_t;
endpackage
`default_nettype wire
